// ==== port_setup_defs.vh ====
`ifndef PORT_SETUP_DEFS_VH
`define PORT_SETUP_DEFS_VH

// Register kind sits in host_addr[7:4], port number in host_addr[2:0].
`define KIND_LEVEL_IN 4'h0
`define KIND_LEVEL_OUT 4'h1
`define KIND_DIRECTION 4'h2
`define KIND_DRIVE_TYPE 4'h3
`define KIND_MODE_SELECT 4'h4
`define KIND_OUT_CELL 4'h5
`define KIND_OUT_BLOCK 4'h6
`define KIND_IN_CELL 4'h7
`define KIND_DRV_ENABLE 4'h8

// Field positions of the host offset.
`define ADDR_KIND_MSB 7
`define ADDR_KIND_LSB 4
`define ADDR_GAP_BIT 3
`define ADDR_PORT_MSB 2

// Port numbers.
`define PORT_A 3'h0
`define PORT_B 3'h1
`define PORT_C 3'h2
`define PORT_D 3'h3
`define PORT_E 3'h4
`define PORT_F 3'h5
`define PORT_G 3'h6
`define PORT_COUNT 7

// Implemented bit sets.
`define BITS_FULL 8'hff
`define BITS_NIBBLE 8'h0f
`define BITS_NONE 8'h00

// Power-up value of every configuration register.
`define CFG_RESET 8'h00
`define CELL_RESET 8'h00
`define RDATA_IDLE 8'h00

`endif

// ==== pin_drive_stage.v ====
`timescale 1ns/1ns
// One port's pin drivers: source select, direction, drive type and reset forcing.
module pin_drive_stage (
  // Configuration
  input wire [7:0] direction,
  input wire [7:0] oe_term,
  input wire [7:0] open_drain,
  input wire [7:0] addr_mode,
  // Data sources
  input wire [7:0] addr_bits,
  input wire [7:0] level_out,
  // Overrides
  input wire force_en,
  input wire [7:0] force_val,
  input wire gpio_off,
  // Pins
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe,
  output wire [7:0] driver_on
);

  wire [7:0] normal_on;
  wire [7:0] normal_val;
  wire [7:0] drive_val;
  wire [7:0] od_active;

  // Direction bit ORed with the logic enable term, both dropped while gpio_off; a zero term leaves direction alone.
  assign normal_on = gpio_off ? 8'h00 : (direction | oe_term);
  assign normal_val = (addr_mode & addr_bits) | (~addr_mode & level_out);

  // The boot pattern is always driven push-pull so the host sees solid levels.
  assign driver_on = force_en ? 8'hff : normal_on;
  assign drive_val = force_en ? force_val : normal_val;
  assign od_active = force_en ? 8'h00 : open_drain;

  // Open-drain pins only ever pull low; a high is left to the external pull-up.
  assign pin_out = drive_val & ~od_active;
  assign pin_oe = driver_on & (~od_active | ~drive_val);

endmodule // pin_drive_stage

// ==== port_setup_registers.v ====
`timescale 1ns/1ns
`include "port_setup_defs.vh"

module port_setup_registers #(
  parameter RESET_PATTERN_EN = 0,
  parameter [15:0] RESET_PATTERN = 16'h0000,
  parameter DATA_PORT_MODE = 0,
  parameter G_ADDR_HIGH = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Host register access
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  input wire bus_cycle,
  // Latched host address for address-out pins
  input wire [15:0] addr_latch,
  // Pins, seven ports of eight bits, port A lowest
  input wire [55:0] pin_in,
  output wire [55:0] pin_out,
  output wire [55:0] pin_oe,
  // Programmable logic side
  input wire [55:0] pld_oe,
  input wire [15:0] omc_next,
  input wire omc_update,
  input wire imc_capture,
  output wire [15:0] omc_q,
  output wire [23:0] imc_q
);

  // Implemented bits of one register kind on one port; zero means no such register.
  function [7:0] reg_mask;
    input [3:0] kind;
    input [2:0] port;
    begin
      reg_mask = `BITS_NONE;
      case (kind)
        `KIND_LEVEL_IN, `KIND_LEVEL_OUT, `KIND_DIRECTION: begin
          if (port == `PORT_D) begin
            reg_mask = `BITS_NIBBLE;
          end else if (port <= `PORT_G) begin
            reg_mask = `BITS_FULL;
          end
        end
        `KIND_DRIVE_TYPE: begin
          if (port == `PORT_D) begin
            reg_mask = `BITS_NIBBLE;
          end else if (port == `PORT_A || port == `PORT_B || port == `PORT_E ||
                       port == `PORT_G) begin
            reg_mask = `BITS_FULL;
          end
        end
        `KIND_MODE_SELECT: begin
          if (port == `PORT_E || port == `PORT_F || port == `PORT_G) begin
            reg_mask = `BITS_FULL;
          end
        end
        `KIND_OUT_CELL, `KIND_OUT_BLOCK: begin
          if (port == `PORT_A || port == `PORT_B) begin
            reg_mask = `BITS_FULL;
          end
        end
        `KIND_IN_CELL: begin
          if (port <= `PORT_C) begin
            reg_mask = `BITS_FULL;
          end
        end
        `KIND_DRV_ENABLE: begin
          if (port <= `PORT_C || port == `PORT_F) begin
            reg_mask = `BITS_FULL;
          end
        end
        default: begin
          reg_mask = `BITS_NONE;
        end
      endcase
    end
  endfunction

  reg [55:0] mode_select;
  reg [55:0] direction;
  reg [55:0] drive_type;
  reg [55:0] level_out;
  reg [15:0] out_cell;
  reg [15:0] out_block;
  reg [23:0] in_cell;

  reg [55:0] next_mode_select;
  reg [55:0] next_direction;
  reg [55:0] next_drive_type;
  reg [55:0] next_level_out;
  reg [15:0] next_out_cell;
  reg [15:0] next_out_block;
  reg [7:0] next_rdata;

  wire [3:0] acc_kind;
  wire [2:0] acc_port;
  wire [7:0] acc_mask;
  wire [55:0] driver_on;
  wire pattern_drive;

  assign acc_kind = host_addr[`ADDR_KIND_MSB:`ADDR_KIND_LSB];
  assign acc_port = host_addr[`ADDR_PORT_MSB:0];
  // Offsets with the gap bit set read as zero; a write there zeroes that port's register of the kind, output cells excepted.
  assign acc_mask = host_addr[`ADDR_GAP_BIT] ? `BITS_NONE : reg_mask(acc_kind, acc_port);

  // Only while reset is held and the host bus is quiet, so no contention with a cycle.
  assign pattern_drive = (RESET_PATTERN_EN != 0) && reset && !bus_cycle;

  assign omc_q = out_cell;
  assign imc_q = in_cell;

  // Write decode: each write touches only the implemented bits of one port.
  always @* begin : write_decode
    integer p;
    integer b;
    p = 0;
    b = 0;
    next_mode_select = mode_select;
    next_direction = direction;
    next_drive_type = drive_type;
    next_level_out = level_out;
    next_out_cell = out_cell;
    next_out_block = out_block;
    if (host_wr) begin
      for (p = 0; p < `PORT_COUNT; p = p + 1) begin
        if (acc_port == p[2:0]) begin
          case (acc_kind)
            `KIND_MODE_SELECT: begin
              next_mode_select[p*8 +: 8] = host_wdata & acc_mask;
            end
            `KIND_DIRECTION: begin
              next_direction[p*8 +: 8] = host_wdata & acc_mask;
            end
            `KIND_DRIVE_TYPE: begin
              next_drive_type[p*8 +: 8] = host_wdata & acc_mask;
            end
            `KIND_LEVEL_OUT: begin
              next_level_out[p*8 +: 8] = host_wdata & acc_mask;
            end
            `KIND_OUT_BLOCK: begin
              if (p < 2) begin
                next_out_block[p*8 +: 8] = host_wdata & acc_mask;
              end
            end
            default: begin
              next_level_out = next_level_out;
            end
          endcase
        end
      end
    end
    // Output cells: an unblocked host write wins over the logic update in the same cycle.
    if (omc_update) begin
      next_out_cell = omc_next;
    end
    if (host_wr && acc_kind == `KIND_OUT_CELL) begin
      for (p = 0; p < 2; p = p + 1) begin
        if (acc_port == p[2:0]) begin
          for (b = 0; b < 8; b = b + 1) begin
            if (acc_mask[b] && !out_block[p*8 + b]) begin
              next_out_cell[p*8 + b] = host_wdata[b];
            end
          end
        end
      end
    end
  end

  // Read decode: unmapped offsets and unimplemented bits read as zero.
  always @* begin : read_decode
    integer p;
    p = 0;
    next_rdata = `RDATA_IDLE;
    for (p = 0; p < `PORT_COUNT; p = p + 1) begin
      if (acc_port == p[2:0]) begin
        case (acc_kind)
          `KIND_LEVEL_IN: begin
            next_rdata = pin_in[p*8 +: 8] & acc_mask;
          end
          `KIND_LEVEL_OUT: begin
            next_rdata = level_out[p*8 +: 8] & acc_mask;
          end
          `KIND_DIRECTION: begin
            next_rdata = direction[p*8 +: 8] & acc_mask;
          end
          `KIND_DRIVE_TYPE: begin
            next_rdata = drive_type[p*8 +: 8] & acc_mask;
          end
          `KIND_MODE_SELECT: begin
            next_rdata = mode_select[p*8 +: 8] & acc_mask;
          end
          `KIND_OUT_CELL: begin
            if (p < 2) begin
              next_rdata = out_cell[p*8 +: 8] & acc_mask;
            end
          end
          `KIND_OUT_BLOCK: begin
            if (p < 2) begin
              next_rdata = out_block[p*8 +: 8] & acc_mask;
            end
          end
          `KIND_IN_CELL: begin
            if (p < 3) begin
              next_rdata = in_cell[p*8 +: 8] & acc_mask;
            end
          end
          `KIND_DRV_ENABLE: begin
            next_rdata = driver_on[p*8 +: 8] & acc_mask;
          end
          default: begin
            next_rdata = `RDATA_IDLE;
          end
        endcase
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      mode_select <= {7{`CFG_RESET}};
      direction <= {7{`CFG_RESET}};
      drive_type <= {7{`CFG_RESET}};
      level_out <= {7{`CFG_RESET}};
      out_cell <= {2{`CELL_RESET}};
      out_block <= {2{`CFG_RESET}};
      in_cell <= {3{`CELL_RESET}};
      host_rdata <= `RDATA_IDLE;
    end else begin
      mode_select <= next_mode_select;
      direction <= next_direction;
      drive_type <= next_drive_type;
      level_out <= next_level_out;
      out_cell <= next_out_cell;
      out_block <= next_out_block;
      // Input cells latch ports A to C on the capture strobe, e.g. an address strobe.
      if (imc_capture) begin
        in_cell <= pin_in[23:0];
      end
      if (host_rd) begin
        host_rdata <= next_rdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PORT_COUNT; g = g + 1) begin : port_slice
      localparam [7:0] OE_MASK = ((g <= 2) || (g == 5)) ? `BITS_FULL : `BITS_NONE;
      localparam IS_FG = (g == 5) || (g == 6);
      wire [7:0] oe_term;
      wire [7:0] addr_byte;
      wire [7:0] pattern_byte;
      wire force_en;
      wire gpio_off;

      // The logic enable term reaches only the logic-connected ports.
      assign oe_term = pld_oe[g*8 +: 8] & OE_MASK;
      assign addr_byte = (g == 6 && G_ADDR_HIGH != 0) ? addr_latch[15:8] : addr_latch[7:0];
      assign pattern_byte = (g == 6) ? RESET_PATTERN[15:8] : RESET_PATTERN[7:0];
      assign force_en = IS_FG && pattern_drive;
      assign gpio_off = IS_FG && (DATA_PORT_MODE != 0);

      pin_drive_stage drive_stage (
        .direction(direction[g*8 +: 8]),
        .oe_term(oe_term),
        .open_drain(drive_type[g*8 +: 8]),
        .addr_mode(mode_select[g*8 +: 8]),
        .addr_bits(addr_byte),
        .level_out(level_out[g*8 +: 8]),
        .force_en(force_en),
        .force_val(pattern_byte),
        .gpio_off(gpio_off),
        .pin_out(pin_out[g*8 +: 8]),
        .pin_oe(pin_oe[g*8 +: 8]),
        .driver_on(driver_on[g*8 +: 8])
      );
    end
  endgenerate

endmodule // port_setup_registers

// ==== port_setup_monitor.sv ====
`timescale 1ns/1ns
module port_setup_monitor #(
  parameter RESET_PATTERN_EN = 0,
  parameter [15:0] RESET_PATTERN = 16'h0000
) (
  // Clock and host side
  input wire sys_clk,
  input wire reset,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata,
  input wire bus_cycle,
  // Pins and logic side
  input wire [55:0] pin_in,
  input wire [55:0] pin_out,
  input wire [55:0] pin_oe,
  input wire [55:0] pld_oe,
  input wire [15:0] omc_next,
  input wire omc_update,
  input wire imc_capture,
  input wire [15:0] omc_q,
  input wire [23:0] imc_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // The boot pattern lives only inside reset, so this one cannot use the reset as disable.
  a_pattern_drive: assert property (disable iff (1'b0)
    (RESET_PATTERN_EN != 0) && reset && !bus_cycle |->
    pin_oe[55:40] == 16'hffff && pin_out[55:40] == RESET_PATTERN) else $error("boot pattern lost");
  a_pattern_release: assert property ($fell(reset) |-> pin_oe[55:48] == 8'h00 &&
    pin_oe[47:40] == pld_oe[47:40] && host_rdata == 8'h00 && omc_q == 16'h0000 &&
    imc_q == 24'h000000) else $error("state after reset wrong");
  a_level_read: assert property (host_rd && host_addr == 8'h00 |=>
    host_rdata == $past(pin_in[7:0])) else $error("live pin read wrong");
  a_dir_oe: assert property (host_wr && host_addr == 8'h22 |=>
    pin_oe[23:16] == ($past(host_wdata) | pld_oe[23:16])) else $error("direction enable wrong");
  a_open_drain: assert property (host_wr && host_addr == 8'h34 && host_wdata == 8'hff |=>
    pin_out[39:32] == 8'h00) else $error("open drain drives high");
  a_port_d_upper: assert property (pin_oe[31:28] == 4'h0) else $error("missing pins driven");
  a_cell_update: assert property (omc_update && !(host_wr && host_addr[7:4] == 4'h5) |=>
    omc_q == $past(omc_next)) else $error("output cell load wrong");
  a_in_capture: assert property (imc_capture |=> imc_q == $past(pin_in[23:0]))
    else $error("input cell capture wrong");
  a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
endmodule // port_setup_monitor

// ==== pin_load_model.sv ====
`timescale 1ns/1ns
module pin_load_model (
  // Clock
  input wire sys_clk,
  input wire reset,
  // Pins
  input wire [55:0] pin_out,
  input wire [55:0] pin_oe,
  input wire [55:0] ext_en,
  input wire [55:0] ext_val,
  output wire [55:0] pin_in,
  output reg [15:0] boot_sample
);
  // Every line has a pull-up, so a released pin reads high unless ext_en lets ext_val drive it.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
  // The host keeps the level seen in the last reset cycle.
  always @(posedge sys_clk) begin
    if (reset) begin
      boot_sample <= pin_in[55:40];
    end
  end
endmodule // pin_load_model

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
  localparam [15:0] PAT = 16'h5ac3;
  reg sys_clk, reset, host_wr, host_rd, bus_cycle, omc_update, imc_capture;
  reg [7:0] host_addr, host_wdata, a, w, d;
  reg [15:0] addr_latch, omc_next;
  reg [55:0] pld_oe, ext_en, ext_val;
  reg [31:0] r;
  wire [7:0] host_rdata;
  wire [55:0] pin_in, pin_out, pin_oe;
  wire [15:0] omc_q, boot_sample;
  wire [23:0] imc_q;
  integer n_mismatch, checks, i;
  port_setup_registers #(.RESET_PATTERN_EN(1), .RESET_PATTERN(PAT)) i_port_setup_registers (
    .sys_clk(sys_clk), .reset(reset), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .bus_cycle(bus_cycle),
    .addr_latch(addr_latch), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pld_oe(pld_oe), .omc_next(omc_next), .omc_update(omc_update), .imc_capture(imc_capture),
    .omc_q(omc_q), .imc_q(imc_q));
  pin_load_model i_pin_load_model (.sys_clk(sys_clk), .reset(reset), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in),
    .boot_sample(boot_sample));
  function [7:0] wmask(input [7:0] x);
    reg [7:0] full;
    begin
      full = (x[2:0] == 3'h3) ? 8'h0f : 8'hff;
      case (x[7:4])
        4'h1, 4'h2: wmask = full;
        4'h3: wmask = (x[2:0] == 3'h2 || x[2:0] == 3'h5) ? 8'h00 : full;
        4'h4: wmask = (x[2:0] >= 3'h4) ? full : 8'h00;
        4'h5: wmask = (x[2:0] < 3'h2) ? full : 8'h00;
        default: wmask = 8'h00;
      endcase
      if (x[3] || x[2:0] == 3'h7) wmask = 8'h00;
    end
  endfunction
  task cmp(input string name, input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task wr(input [7:0] x, input [7:0] v);
    begin
      @(posedge sys_clk);
      #1;
      host_addr = x;
      host_wdata = v;
      host_wr = 1;
      @(posedge sys_clk);
      #1;
      host_wr = 0;
    end
  endtask
  task rd(input [7:0] x, output [7:0] v);
    begin
      @(posedge sys_clk);
      #1;
      host_addr = x;
      host_rd = 1;
      @(posedge sys_clk);
      #1;
      host_rd = 0;
      v = host_rdata;
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
  initial begin
    {reset, host_wr, host_rd, bus_cycle, omc_update, imc_capture} = 6'h20;
    {host_addr, host_wdata, addr_latch, omc_next} = 48'h0;
    {pld_oe, ext_en, ext_val} = 168'h0;
    n_mismatch = 0;
    checks = 0;
    r = $urandom(84796);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp("boot oe", 16'hffff, pin_oe[55:40]);
    cmp("boot data", PAT, pin_out[55:40]);
    bus_cycle = 1;
    @(posedge sys_clk);
    #1;
    cmp("boot blocked", 16'h0000, pin_oe[55:40]);
    bus_cycle = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 0;
    // The pins follow reset combinationally, so let the release settle before looking.
    #1;
    cmp("boot sample", PAT, boot_sample);
    cmp("after boot", 16'h0000, pin_oe[55:40]);
    for (i = 0; i < 70; i = i + 1) begin
      r = $urandom;
      a = {{1'b0, r[6:4] % 3'd5} + 4'h1, r[9:7] == 3'h0, r[2:0]};
      w = r[31:24];
      pld_oe[23:0] = r[31:8];
      case (i)
        0: a = 8'h23;
        1: a = 8'h33;
        2: a = 8'h42;
        3: a = 8'h1b;
        default: ;
      endcase
      wr(a, w);
      rd(a, d);
      cmp("read back", {8'h00, w & wmask(a)}, {8'h00, d});
    end
    pld_oe = 56'h0;
    r = $urandom;
    ext_en[23:0] = 24'hffffff;
    ext_val[23:0] = r[23:0];
    for (i = 0; i < 3; i = i + 1) wr(8'h20 + i[7:0], 8'h00);
    rd(8'h00, d);
    cmp("level in", {8'h00, ext_val[7:0]}, {8'h00, d});
    imc_capture = 1;
    @(posedge sys_clk);
    #1;
    imc_capture = 0;
    rd(8'h72, d);
    cmp("in cell", {8'h00, ext_val[23:16]}, {8'h00, d});
    pld_oe[23:16] = 8'h10;
    wr(8'h22, 8'h07);
    wr(8'h82, 8'hff);
    rd(8'h82, d);
    cmp("driver on", 16'h0017, {8'h00, d});
    rd(8'h83, d);
    cmp("no register", 16'h0000, {8'h00, d});
    addr_latch = r[15:0];
    w = r[31:24];
    wr(8'h44, 8'h00);
    wr(8'h34, 8'h00);
    wr(8'h14, w);
    wr(8'h24, 8'hff);
    cmp("port out", {8'hff, w}, {pin_oe[39:32], pin_out[39:32]});
    wr(8'h44, 8'hff);
    cmp("addr out", {8'h00, addr_latch[7:0]}, {8'h00, pin_out[39:32]});
    wr(8'h34, 8'hff);
    cmp("open drain", {8'h00, ~addr_latch[7:0]}, {8'h00, pin_oe[39:32]});
    wr(8'h46, 8'hff);
    wr(8'h36, 8'h00);
    wr(8'h26, 8'hff);
    cmp("addr high", {8'h00, addr_latch[15:8]}, {8'h00, pin_out[55:48]});
    wr(8'h50, 8'h00);
    wr(8'h60, 8'hf0);
    wr(8'h50, 8'hff);
    rd(8'h50, d);
    cmp("blocked load", 16'h000f, {8'h00, d});
    rd(8'h60, d);
    cmp("load block", 16'h00f0, {8'h00, d});
    omc_next = r[15:0];
    omc_update = 1;
    @(posedge sys_clk);
    #1;
    omc_update = 0;
    cmp("cell update", omc_next, omc_q);
    // Give the checker the edges it needs to finish its last pending properties.
    repeat (2) @(posedge sys_clk);
    end_sim;
  end
endmodule // testbench
bind port_setup_registers port_setup_monitor #(.RESET_PATTERN_EN(RESET_PATTERN_EN),
  .RESET_PATTERN(RESET_PATTERN)) i_port_setup_monitor (.sys_clk(sys_clk), .reset(reset),
  .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .bus_cycle(bus_cycle), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pld_oe(pld_oe), .omc_next(omc_next), .omc_update(omc_update),
  .imc_capture(imc_capture), .omc_q(omc_q), .imc_q(imc_q));
